// [hw/bus_release_pkg.sv]
package bus_release_pkg;
	// module-stop values: the two all-stop values halt the release function in sleep, plus the reset value
	localparam logic [15:0] ALL_STOP_A      = 16'hFFFF;
	localparam logic [15:0] ALL_STOP_B      = 16'hEFFF;
	localparam logic [15:0] MODULE_STOP_RST = 16'h3FFF;
	// bus owner, one-hot
	typedef enum logic [2:0] {
		OWN_NONE = 3'h1,
		OWN_CPU  = 3'h2,
		OWN_TC   = 3'h4
	} owner_t;
	// external bus release state, one-hot
	typedef enum logic [1:0] {
		REL_HELD     = 2'h1,
		REL_RELEASED = 2'h2
	} rel_state_t;
endpackage : bus_release_pkg

// [hw/external_bus_release_arbiter.sv]
// Behaviour
// - release only in expansion mode with enable set
// - request low: acknowledge low, pins high impedance
// - external cycles wait while bus released
// - pending external access drives drop request low
// - request high ends release, acknowledge high
// - release request beats simultaneous external access
// - address, data, strobes, selects all undriven
// - all-stop value in sleep stops release
// - grant highest requester, hold until withdrawn
// - cpu lowest, transfer controller takes bus
// - internal accesses continue during release
// - cpu yields only between whole bus cycles
// - sleeping cpu yields immediately
// - activation raises transfer controller bus request
// - transfer controller yields only at step ends
// - release only after external cycle completes
// - power-on reset abandons everything at once
// - manual reset keeps state, ignores wait
`timescale 1ns/10ps
`default_nettype none
module external_bus_release_arbiter (
	// clock and resets
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        manual_reset,
	// mode and control bits
	input  wire logic        ext_mode,
	input  wire logic        release_enable_bit,
	input  wire logic        request_out_enable,
	input  wire logic        sleep_mode,
	input  wire logic [15:0] module_stop_ctrl,
	// external master handshake
	input  wire logic        ext_bus_request_n,
	output logic             ext_bus_ack_n,
	output logic             drop_request_out_n,
	// pin output enables, high while driving
	output logic             addr_oe,
	output logic             data_oe,
	output logic             chip_select_oe,
	output logic             addr_strobe_oe,
	output logic             read_strobe_oe,
	output logic             upper_write_strobe_oe,
	output logic             lower_write_strobe_oe,
	// bus controller cycle status
	input  wire logic        ext_cycle_busy,
	input  wire logic        write_cycle,
	output logic             wait_ignore,
	// cpu master
	input  wire logic        cpu_bus_req,
	input  wire logic        cpu_cycle_boundary,
	input  wire logic        cpu_ext_req,
	output logic             cpu_ack,
	// transfer controller master
	input  wire logic        tc_activation,
	input  wire logic        tc_done,
	input  wire logic        tc_release_point,
	input  wire logic        tc_ext_req,
	output logic             tc_ack,
	// start of an external cycle for the owner, and internal access permission
	output logic             ext_cycle_go,
	output logic             int_access_ok
);
	import bus_release_pkg::*;

	owner_t     owner;
	owner_t     next_owner;
	rel_state_t rel;
	logic       tc_req;
	logic       rel_allowed;
	logic       want_release;
	logic       owner_ext;
	logic       enter_release;

	// all-stop values in sleep
	function automatic logic is_all_stop(input logic [15:0] v);
		is_all_stop = (v == ALL_STOP_A) || (v == ALL_STOP_B);
	endfunction : is_all_stop

	// release is legal only in expansion mode and enabled, not stopped
	assign rel_allowed   = ext_mode & release_enable_bit
		& ~(sleep_mode & is_all_stop(module_stop_ctrl));
	assign want_release  = rel_allowed & ~ext_bus_request_n;
	// a running external cycle finishes first, so no strobe floats mid cycle
	assign enter_release = (rel == REL_HELD) & want_release & ~ext_cycle_busy;
	assign owner_ext     = (owner == OWN_CPU & cpu_ext_req) | (owner == OWN_TC & tc_ext_req);

	// transfer controller request, activation wins over done
	always_ff @(posedge clk) begin
		if (srst) begin
			tc_req <= 1'h0;
		end else if (tc_activation) begin
			tc_req <= 1'h1;
		end else if (tc_done) begin
			tc_req <= 1'h0;
		end
	end

	// arbitration: tc above cpu; owner keeps bus until it may yield
	always_comb begin
		next_owner = owner;
		case (owner)
			OWN_NONE: begin
				if (tc_req) begin
					next_owner = OWN_TC;
				end else if (cpu_bus_req) begin
					next_owner = OWN_CPU;
				end
			end
			OWN_CPU: begin
				// never between halves of a longword access unless the cpu sleeps
				if (tc_req && (cpu_cycle_boundary || sleep_mode)) begin
					next_owner = OWN_TC;
				end else if (!cpu_bus_req && cpu_cycle_boundary) begin
					next_owner = OWN_NONE;
				end
			end
			OWN_TC: begin
				if (!tc_req && tc_release_point) begin
					next_owner = cpu_bus_req ? OWN_CPU : OWN_NONE;
				end
			end
			default: next_owner = OWN_NONE;
		endcase
	end

	// owner register; manual reset freezes grants but keeps state
	always_ff @(posedge clk) begin
		if (srst) begin
			owner <= OWN_NONE;
		end else if (!manual_reset) begin
			owner <= next_owner;
		end
	end

	// release state machine
	always_ff @(posedge clk) begin
		if (srst) begin
			rel <= REL_HELD;
		end else begin
			case (rel)
				REL_HELD: begin
					if (enter_release) begin
						rel <= REL_RELEASED;
					end
				end
				REL_RELEASED: begin
					if (ext_bus_request_n) begin
						rel <= REL_HELD;
					end
				end
				default: rel <= REL_HELD;
			endcase
		end
	end

	// handshake follows the release state; wait ignore follows manual reset
	always_ff @(posedge clk) begin
		if (srst) begin
			ext_bus_ack_n      <= 1'h1;
			drop_request_out_n <= 1'h1;
			wait_ignore        <= 1'h0;
		end else begin
			ext_bus_ack_n      <= ~(rel == REL_RELEASED);
			drop_request_out_n <= ~(request_out_enable & (rel == REL_RELEASED) & owner_ext);
			wait_ignore        <= manual_reset;
		end
	end

	// all address, data and control pins float while released
	always_ff @(posedge clk) begin
		if (srst) begin
			addr_oe               <= 1'h0;
			data_oe               <= 1'h0;
			chip_select_oe        <= 1'h0;
			addr_strobe_oe        <= 1'h0;
			read_strobe_oe        <= 1'h0;
			upper_write_strobe_oe <= 1'h0;
			lower_write_strobe_oe <= 1'h0;
		end else begin
			addr_oe               <= (rel == REL_HELD);
			data_oe               <= (rel == REL_HELD) & write_cycle & ext_cycle_busy;
			chip_select_oe        <= (rel == REL_HELD);
			addr_strobe_oe        <= (rel == REL_HELD);
			read_strobe_oe        <= (rel == REL_HELD);
			upper_write_strobe_oe <= (rel == REL_HELD);
			lower_write_strobe_oe <= (rel == REL_HELD);
		end
	end

	// grants; internal accesses never wait on the external bus
	assign cpu_ack       = (owner == OWN_CPU);
	assign tc_ack        = (owner == OWN_TC);
	assign int_access_ok = (owner != OWN_NONE) & ~srst;
	// external start: blocked when released or release wins this cycle
	assign ext_cycle_go  = owner_ext & (rel == REL_HELD) & ~want_release
		& ~srst & ~manual_reset;

	// assertions
	property p_no_release_disabled;
		@(posedge clk) disable iff (srst)
		(rel == REL_HELD && !rel_allowed) |=> (rel == REL_HELD);
	endproperty
	a_no_release_disabled: assert property (p_no_release_disabled)
		else $error("release entered while not allowed");

	property p_ack_follows;
		@(posedge clk) disable iff (srst)
		enter_release |=> (rel == REL_RELEASED) ##1 !ext_bus_ack_n;
	endproperty
	a_ack_follows: assert property (p_ack_follows)
		else $error("acknowledge not driven low after release");

	property p_no_ext_released;
		@(posedge clk) disable iff (srst)
		(rel == REL_RELEASED) |-> !ext_cycle_go;
	endproperty
	a_no_ext_released: assert property (p_no_ext_released)
		else $error("external cycle started while released");

	property p_drop_req;
		@(posedge clk) disable iff (srst)
		(request_out_enable && rel == REL_RELEASED && owner_ext) |=> !drop_request_out_n;
	endproperty
	a_drop_req: assert property (p_drop_req)
		else $error("drop request not driven");

	property p_end_release;
		@(posedge clk) disable iff (srst)
		(rel == REL_RELEASED && ext_bus_request_n) |=> ##1 ext_bus_ack_n;
	endproperty
	a_end_release: assert property (p_end_release)
		else $error("acknowledge not released");

	property p_release_priority;
		@(posedge clk) disable iff (srst)
		(want_release && owner_ext) |-> !ext_cycle_go;
	endproperty
	a_release_priority: assert property (p_release_priority)
		else $error("external access beat release request");

	property p_pins_float;
		@(posedge clk) disable iff (srst)
		(rel == REL_RELEASED) [*2] |-> !addr_oe && !data_oe && !chip_select_oe
			&& !addr_strobe_oe && !read_strobe_oe
			&& !upper_write_strobe_oe && !lower_write_strobe_oe;
	endproperty
	a_pins_float: assert property (p_pins_float)
		else $error("pin driven while released");

	property p_sleep_stop;
		@(posedge clk) disable iff (srst)
		(sleep_mode && is_all_stop(module_stop_ctrl) && rel == REL_HELD) |=> (rel == REL_HELD);
	endproperty
	a_sleep_stop: assert property (p_sleep_stop)
		else $error("release in sleep with all-stop value");

	property p_tc_priority;
		@(posedge clk) disable iff (srst || manual_reset)
		(owner == OWN_NONE && tc_req) |=> tc_ack;
	endproperty
	a_tc_priority: assert property (p_tc_priority)
		else $error("transfer controller not granted first");

	property p_cpu_boundary;
		@(posedge clk) disable iff (srst)
		(cpu_ack && !cpu_cycle_boundary && !sleep_mode) |=> cpu_ack;
	endproperty
	a_cpu_boundary: assert property (p_cpu_boundary)
		else $error("cpu lost bus inside a cycle");

	property p_cpu_sleep;
		@(posedge clk) disable iff (srst || manual_reset)
		(cpu_ack && sleep_mode && tc_req) |=> tc_ack;
	endproperty
	a_cpu_sleep: assert property (p_cpu_sleep)
		else $error("sleeping cpu kept the bus");

	property p_tc_req;
		@(posedge clk) disable iff (srst)
		tc_activation |=> tc_req;
	endproperty
	a_tc_req: assert property (p_tc_req)
		else $error("activation lost");

	property p_tc_hold;
		@(posedge clk) disable iff (srst)
		(tc_ack && !tc_release_point) |=> tc_ack;
	endproperty
	a_tc_hold: assert property (p_tc_hold)
		else $error("transfer controller yielded mid step");

	property p_cycle_done;
		@(posedge clk) disable iff (srst)
		(rel == REL_HELD && ext_cycle_busy) |=> (rel == REL_HELD);
	endproperty
	a_cycle_done: assert property (p_cycle_done)
		else $error("release during external cycle");

	property p_manual_hold;
		@(posedge clk) disable iff (srst)
		manual_reset |=> $stable(owner) && wait_ignore;
	endproperty
	a_manual_hold: assert property (p_manual_hold)
		else $error("manual reset changed owner");

	property p_por;
		@(posedge clk) srst |=> (owner == OWN_NONE) && (rel == REL_HELD) && ext_bus_ack_n;
	endproperty
	a_por: assert property (p_por)
		else $error("power-on reset not immediate");

	// handover and reset guards
	property p_held_drives;
		@(posedge clk) disable iff (srst)
		(rel == REL_HELD) [*2] |-> ext_bus_ack_n && addr_oe && chip_select_oe;
	endproperty
	a_held_drives: assert property (p_held_drives)
		else $error("pins or acknowledge not back after release ended");

	property p_tc_yield;
		@(posedge clk) disable iff (srst || manual_reset)
		(tc_ack && !tc_req && tc_release_point && cpu_bus_req) |=> cpu_ack;
	endproperty
	a_tc_yield: assert property (p_tc_yield)
		else $error("transfer controller kept bus at release point");

	property p_wait_follow;
		@(posedge clk) disable iff (srst)
		!manual_reset |=> !wait_ignore;
	endproperty
	a_wait_follow: assert property (p_wait_follow)
		else $error("wait ignored outside manual reset");

	// main scenarios
	c_release: cover property (@(posedge clk) disable iff (srst)
		enter_release ##[1:20] (rel == REL_RELEASED && ext_bus_request_n));
	c_drop: cover property (@(posedge clk) disable iff (srst) !drop_request_out_n);
	c_cpu_to_tc: cover property (@(posedge clk) disable iff (srst) cpu_ack ##1 tc_ack);
	c_parallel: cover property (@(posedge clk) disable iff (srst)
		(rel == REL_RELEASED) && int_access_ok);
	c_refused: cover property (@(posedge clk) disable iff (srst)
		want_release && ext_cycle_busy);
endmodule : external_bus_release_arbiter
`default_nettype wire

// [test/ext_master.sv]
`timescale 1ns/10ps
`default_nettype none
// outside master: keeps its request low until the bench lets go, or until a drop request comes while obey is set
module ext_master (
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// bench control
	input  wire logic want,
	input  wire logic obey,
	// bus handshake
	input  wire logic drop_request_out_n,
	output logic      ext_bus_request_n
);
	// changes just after an edge; the line idles high like a pulled-up pin
	always_ff @(posedge clk) begin
		if (srst) begin
			ext_bus_request_n <= 1'h1;
		end else begin
			ext_bus_request_n <= !(want && !(obey && !drop_request_out_n));
		end
	end
endmodule : ext_master
`default_nettype wire

// [test/external_bus_release_arbiter_test.sv]
`timescale 1ns/10ps
`default_nettype none
module external_bus_release_arbiter_test;
	import bus_release_pkg::*;
	typedef struct {int at; logic [8:0] m; logic [8:0] v;} note_t;
	localparam logic [8:0] ACK = 9'h100, DRP = 9'h080, AOE = 9'h040, DOE = 9'h020;
	localparam logic [8:0] CAK = 9'h010, TAK = 9'h008, GO = 9'h004, WIG = 9'h002;
	localparam logic [8:0] IOK = 9'h001;
	logic clk = 1'h0, srst, manual_reset, ext_mode, release_enable_bit, request_out_enable;
	logic sleep_mode, ext_cycle_busy, write_cycle, cpu_bus_req, cpu_cycle_boundary;
	logic cpu_ext_req, tc_activation, tc_done, tc_release_point, tc_ext_req, want, obey;
	logic [15:0] module_stop_ctrl;
	wire logic ext_bus_request_n, ext_bus_ack_n, drop_request_out_n, addr_oe, data_oe;
	wire logic wait_ignore, cpu_ack, tc_ack, ext_cycle_go, int_access_ok;
	wire logic [8:0] obs = {ext_bus_ack_n, drop_request_out_n, addr_oe, data_oe, cpu_ack,
		tc_ack, ext_cycle_go, wait_ignore, int_access_ok};
	wire logic chip_select_oe, addr_strobe_oe, read_strobe_oe, upper_write_strobe_oe;
	wire logic lower_write_strobe_oe;
	wire logic [4:0] pins = {chip_select_oe, addr_strobe_oe, read_strobe_oe,
		upper_write_strobe_oe, lower_write_strobe_oe};
	note_t note_q[$];
	note_t nt;
	int cyc = 0, fails = 0, check_count = 0;

	external_bus_release_arbiter i_external_bus_release_arbiter (.clk, .srst,
		.manual_reset, .ext_mode, .release_enable_bit, .request_out_enable, .sleep_mode,
		.module_stop_ctrl, .ext_bus_request_n, .ext_bus_ack_n, .drop_request_out_n,
		.addr_oe, .data_oe, .chip_select_oe, .addr_strobe_oe, .read_strobe_oe,
		.upper_write_strobe_oe, .lower_write_strobe_oe, .ext_cycle_busy, .write_cycle,
		.wait_ignore, .cpu_bus_req, .cpu_cycle_boundary, .cpu_ext_req, .cpu_ack,
		.tc_activation, .tc_done, .tc_release_point, .tc_ext_req, .tc_ack, .ext_cycle_go,
		.int_access_ok);
	ext_master i_ext_master (.clk, .srst, .want, .obey, .drop_request_out_n,
		.ext_bus_request_n);

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	task automatic conclude();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude
	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			conclude();
		end
	end
	task automatic chk(string n, logic [8:0] seen, logic [8:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s exp %h seen %h", n, exp, seen);
		end
	endtask : chk
	// outputs settle after the edge, so the watcher looks on the falling edge
	always @(negedge clk) begin
		while (note_q.size() > 0 && note_q[0].at <= cyc) begin
			nt = note_q.pop_front();
			chk("outputs", obs & nt.m, nt.v);
			if ((nt.m & AOE) != 9'h000) begin
				chk("pins", {4'h0, pins}, (nt.v & AOE) != 9'h000 ? 9'h01F : 9'h000);
			end
		end
	end
	task automatic note(int d, logic [8:0] m, logic [8:0] v);
		note_q.push_back('{cyc + d, m, v});
	endtask : note
	task automatic tick(int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic wait_bit(logic [8:0] m);
		int n;
		n = 0;
		while ((obs & m) === 9'h000 && n < 10) begin
			tick(1);
			n++;
		end
	endtask : wait_bit
	// one full request from the outside master; partner adds one edge of delay
	task automatic rel(int hold, logic ok);
		want = 1'h1;
		note(3, ACK | AOE, ok ? 9'h000 : ACK | AOE);
		tick(3 + hold);
		want = 1'h0;
		note(3, ACK | AOE, ACK | AOE);
		tick(4);
	endtask : rel

	initial begin
		{srst, manual_reset, ext_mode, release_enable_bit, request_out_enable, sleep_mode,
			ext_cycle_busy, write_cycle, cpu_bus_req, cpu_cycle_boundary, cpu_ext_req,
			tc_activation, tc_done, tc_release_point, tc_ext_req, want, obey} = 0;
		module_stop_ctrl = MODULE_STOP_RST;
		srst = 1'h1;
		void'($urandom(31));
		tick(12);
		srst = 1'h0;
		note(1, ~DOE, ACK | DRP | AOE);
		for (int i = 0; i < 4; i++) begin
			{ext_mode, release_enable_bit} = i[1:0];
			rel(2, i == 3);
		end
		sleep_mode = 1'h1;
		repeat (3) begin
			module_stop_ctrl = 16'($urandom_range(0, 16'hEFFE));
			rel($urandom_range(1, 8), 1'h1);
		end
		module_stop_ctrl = ALL_STOP_A;
		rel(2, 1'h0);
		module_stop_ctrl = ALL_STOP_B;
		rel(2, 1'h0);
		{sleep_mode, ext_cycle_busy, write_cycle} = 3'h3;
		note(1, DOE, DOE);
		want = 1'h1;
		tick(6);
		note(1, ACK, ACK);
		ext_cycle_busy = 1'h0;
		note(2, ACK | DOE, 9'h000);
		tick(3);
		want = 1'h0;
		{cpu_bus_req, request_out_enable} = 2'h3;
		tick(6);
		note(1, CAK | IOK, CAK | IOK);
		// a running cycle holds the release off, so both requests stand together
		{want, ext_cycle_busy} = 2'h3;
		tick(1);
		cpu_ext_req = 1'h1;
		note(1, GO, 9'h000);
		tick(1);
		ext_cycle_busy = 1'h0;
		note(2, ACK | DRP | GO | IOK | CAK, IOK | CAK);
		tick(2);
		obey = 1'h1;
		note(3, ACK | DRP | GO, ACK | DRP | GO);
		tick(1);
		want = 1'h0;
		tick(4);
		{obey, cpu_ext_req} = 2'h0;
		for (int k = 0; k < 2; k++) begin
			tc_activation = 1'h1;
			tick(1);
			tc_activation = 1'h0;
			tick(5);
			note(1, CAK | TAK, CAK);
			tick(1);
			if (k == 0) sleep_mode = 1'h1;
			else cpu_cycle_boundary = 1'h1;
			wait_bit(TAK);
			tc_ext_req = 1'h1;
			note(1, CAK | TAK | IOK | GO, TAK | IOK | GO);
			tc_done = 1'h1;
			tick(1);
			tc_done = 1'h0;
			tick(4);
			note(1, TAK, TAK);
			tick(1);
			tc_release_point = 1'h1;
			wait_bit(CAK);
			note(1, CAK | TAK, CAK);
			{sleep_mode, cpu_cycle_boundary, tc_release_point, tc_ext_req} = 4'h0;
			tick(2);
		end
		{manual_reset, cpu_ext_req} = 2'h3;
		note(1, WIG | CAK, WIG | CAK);
		tc_activation = 1'h1;
		tick(1);
		tc_activation = 1'h0;
		note(3, TAK | GO, 9'h000);
		tick(4);
		{manual_reset, cpu_ext_req} = 2'h0;
		want = 1'h1;
		tick(5);
		{srst, want} = 2'h2;
		note(1, ACK | CAK | GO, ACK);
		tick(2);
		srst = 1'h0;
		tick(5);
		conclude();
	end
endmodule : external_bus_release_arbiter_test
`default_nettype wire
